// *** inc/hoaio_map.svh ***
// Named constants for the heater override and alarm node.
`ifndef HOAIO_MAP_SVH
`define HOAIO_MAP_SVH

`define HOAIO_CLK_HZ 100000000
`define HOAIO_TICK_US 1000
`define HOAIO_TICK_CYC (`HOAIO_CLK_HZ / 1000000 * `HOAIO_TICK_US)

`define HOAIO_MS_W 16
`define HOAIO_EDIT_S 5
`define HOAIO_EDIT_MS (16'(`HOAIO_EDIT_S * 1000))
`define HOAIO_SHOW_S 5
`define HOAIO_SHOW_MS (16'(`HOAIO_SHOW_S * 1000))
`define HOAIO_ADDR_HOLD_MS 16'd2000
`define HOAIO_TERM_HOLD_MS 16'd4000
`define HOAIO_FLASH_MS 16'd250

`define HOAIO_NODE_RST 8'h01
`define HOAIO_NODE_NONE 8'h00
`define HOAIO_NODE_MAX 8'h99
`define HOAIO_DIGIT_MAX 4'h9

`define HOAIO_NCKT 6
`define HOAIO_NSENS 20
`define HOAIO_TW 16
`define HOAIO_MW 12
`define HOAIO_MAP_NONE 3'h0
`define HOAIO_SUB_MIN 3'h1
`define HOAIO_SUB_MAX 3'h6

`endif

// *** inc/hoaio_pkg.sv ***
// Types shared by the heater override and alarm node.
package hoaio_pkg;

	typedef enum logic [2:0] {
		HOAIO_UI_IDLE,
		HOAIO_UI_HOLD,
		HOAIO_UI_ADDR_EDIT,
		HOAIO_UI_TERM_ARM,
		HOAIO_UI_TERM_SHOW
	} hoaio_ui_state_t;

	typedef enum logic [1:0] {
		HOAIO_DISP_NODE,
		HOAIO_DISP_ADDR,
		HOAIO_DISP_TERM_EN,
		HOAIO_DISP_TERM_VAL
	} hoaio_disp_t;

endpackage : hoaio_pkg

// *** logic/hoaio_circuit.sv ***
// One heater circuit: override handling, relay drive and alarm evaluation.
`timescale 1ns/10ps
`include "hoaio_map.svh"

module hoaio_circuit #(
	parameter int TW = `HOAIO_TW,
	parameter int MW = `HOAIO_MW
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic ckt_enable,
	input wire logic heat_demand,
	input wire logic load_shed_opt,
	input wire logic force_on_opt,
	input wire logic load_shed_in,
	input wire logic force_on_in,
	input wire logic signed [TW-1:0] ctrl_temp,
	input wire logic signed [TW-1:0] high_set,
	input wire logic signed [TW-1:0] low_set,
	input wire logic sensor_fault,
	input wire logic [MW-1:0] leak_current,
	input wire logic [MW-1:0] leak_limit,
	input wire logic over_current,
	output logic relay_on,
	output logic alarm_high,
	output logic alarm_low,
	output logic alarm_trip
);

	logic shed_req;
	logic force_req;
	logic shed_escaped;
	logic force_escaped;
	logic next_high;
	logic next_low;
	logic next_relay;
	logic primed;

	assign shed_req = load_shed_in & load_shed_opt;
	assign force_req = force_on_in & force_on_opt;
	assign next_high = ctrl_temp > high_set;
	assign next_low = (ctrl_temp < low_set) | sensor_fault;

	// An escape holds until the contact that forced the circuit opens again.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			shed_escaped <= 1'b0;
		end else if (!shed_req) begin
			shed_escaped <= 1'b0;
		end else if (alarm_low) begin
			shed_escaped <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			force_escaped <= 1'b0;
		end else if (!force_req) begin
			force_escaped <= 1'b0;
		end else if (alarm_high) begin
			force_escaped <= 1'b1;
		end
	end

	always_comb begin
		if (shed_req && !shed_escaped) begin
			next_relay = 1'b0;
		end else if (shed_req) begin
			next_relay = 1'b1;
		end else if (force_req && !force_escaped) begin
			next_relay = 1'b1;
		end else if (force_req) begin
			next_relay = 1'b0;
		end else begin
			next_relay = ckt_enable & heat_demand;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			relay_on <= 1'b0;
		end else begin
			relay_on <= next_relay;
		end
	end

	// The control temperature holds its cleared value for one cycle after reset.
	// Judging it then would raise a false low alarm and latch a shed escape.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			primed <= 1'b0;
		end else begin
			primed <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			alarm_high <= 1'b0;
			alarm_low <= 1'b0;
			alarm_trip <= 1'b0;
		end else begin
			alarm_high <= primed & next_high;
			alarm_low <= primed & next_low;
			alarm_trip <= over_current | (leak_current > leak_limit);
		end
	end

endmodule : hoaio_circuit

// *** logic/hoaio_top.sv ***
// Heater override and alarm node: addressing, terminator, overrides, alarms.
`timescale 1ns/10ps
`include "hoaio_map.svh"

module hoaio_top #(
	parameter int NCKT = `HOAIO_NCKT,
	parameter int NSENS = `HOAIO_NSENS,
	parameter int TW = `HOAIO_TW,
	parameter int MW = `HOAIO_MW,
	parameter int TICK_CYCLES = `HOAIO_TICK_CYC,
	parameter logic [7:0] NODE_RESET = `HOAIO_NODE_RST
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic button,
	input wire logic [7:0] addr_select,
	input wire logic load_shed_contact,
	input wire logic force_on_contact,
	input wire logic system_fault_in,
	input wire logic [NCKT-1:0] ckt_enable,
	input wire logic [NCKT-1:0] heat_demand,
	input wire logic [NCKT-1:0] load_shed_opt,
	input wire logic [NCKT-1:0] force_on_opt,
	input wire logic [NCKT-1:0] over_current,
	input wire logic signed [TW-1:0] high_set [NCKT],
	input wire logic signed [TW-1:0] low_set [NCKT],
	input wire logic [MW-1:0] leak_limit [NCKT],
	input wire logic [MW-1:0] heater_current_raw [NCKT],
	input wire logic [MW-1:0] leak_current_raw [NCKT],
	input wire logic signed [TW-1:0] sensor_temp [NSENS],
	input wire logic [NSENS-1:0] sensor_fault,
	input wire logic [2:0] sensor_map [NSENS],
	input wire logic [2:0] sub_addr,
	output logic [7:0] node_code,
	output logic node_code_valid,
	output logic term_enable,
	output logic term_led,
	output logic [7:0] disp_code,
	output hoaio_pkg::hoaio_disp_t disp_mode,
	output logic disp_lit,
	output logic load_shed_on,
	output logic force_on_on,
	output logic [NCKT-1:0] relay_on,
	output logic [NCKT-1:0] alarm_high,
	output logic [NCKT-1:0] alarm_low,
	output logic [NCKT-1:0] alarm_trip,
	output logic signed [TW-1:0] ctrl_temp [NCKT],
	output logic [MW-1:0] heater_current [NCKT],
	output logic [MW-1:0] leak_current [NCKT],
	output logic sel_valid,
	output logic sel_relay,
	output logic [MW-1:0] sel_heater_current,
	output logic [MW-1:0] sel_leak_current,
	output logic out_common_ok,
	output logic out_trip_ok,
	output logic out_high_ok,
	output logic out_low_ok,
	output logic out_system_ok
);

	localparam int TCW = $clog2(TICK_CYCLES + 1);

	hoaio_pkg::hoaio_ui_state_t ui_state;
	hoaio_pkg::hoaio_ui_state_t next_ui_state;
	logic [TCW-1:0] tick_cnt;
	logic tick_ms;
	logic [`HOAIO_MS_W-1:0] ms_cnt;
	logic [`HOAIO_MS_W-1:0] flash_cnt;
	logic flash_phase;
	logic button_q;
	logic press;
	logic restart_ms;
	logic signed [TW-1:0] next_ctrl_temp [NCKT];
	logic [NCKT-1:0] next_sensor_fault;
	logic signed [TW-1:0] lo_val;
	logic signed [TW-1:0] hi_val;
	logic seen;
	logic above;
	logic flt;

	function automatic logic code_ok(input logic [7:0] code);
		code_ok = (code[7:4] <= `HOAIO_DIGIT_MAX) && (code[3:0] <= `HOAIO_DIGIT_MAX)
			&& (code != `HOAIO_NODE_NONE) && (code <= `HOAIO_NODE_MAX);
	endfunction : code_ok

	// Millisecond enable pulse for all button and display timing.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= '0;
		end else if (tick_cnt == TCW'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	assign tick_ms = (tick_cnt == TCW'(TICK_CYCLES - 1));

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			button_q <= 1'b0;
		end else begin
			button_q <= button;
		end
	end

	assign press = button & ~button_q;

	always_comb begin
		next_ui_state = ui_state;
		case (ui_state)
			hoaio_pkg::HOAIO_UI_IDLE: begin
				if (press) begin
					next_ui_state = hoaio_pkg::HOAIO_UI_HOLD;
				end
			end
			hoaio_pkg::HOAIO_UI_HOLD: begin
				if (!button) begin
					if (ms_cnt >= `HOAIO_ADDR_HOLD_MS) begin
						next_ui_state = hoaio_pkg::HOAIO_UI_ADDR_EDIT;
					end else begin
						next_ui_state = hoaio_pkg::HOAIO_UI_IDLE;
					end
				end else if (ms_cnt >= `HOAIO_TERM_HOLD_MS) begin
					next_ui_state = hoaio_pkg::HOAIO_UI_TERM_ARM;
				end
			end
			hoaio_pkg::HOAIO_UI_ADDR_EDIT: begin
				if (press || ms_cnt >= `HOAIO_EDIT_MS) begin
					next_ui_state = hoaio_pkg::HOAIO_UI_IDLE;
				end
			end
			hoaio_pkg::HOAIO_UI_TERM_ARM: begin
				if (!button) begin
					next_ui_state = hoaio_pkg::HOAIO_UI_TERM_SHOW;
				end
			end
			hoaio_pkg::HOAIO_UI_TERM_SHOW: begin
				if (!press && ms_cnt >= `HOAIO_SHOW_MS) begin
					next_ui_state = hoaio_pkg::HOAIO_UI_IDLE;
				end
			end
			default: begin
				next_ui_state = hoaio_pkg::HOAIO_UI_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ui_state <= hoaio_pkg::HOAIO_UI_IDLE;
		end else begin
			ui_state <= next_ui_state;
		end
	end

	// A toggle press restarts the five-second display of the terminator value.
	assign restart_ms = (next_ui_state != ui_state)
		|| (ui_state == hoaio_pkg::HOAIO_UI_TERM_SHOW && press);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ms_cnt <= '0;
		end else if (restart_ms) begin
			ms_cnt <= '0;
		end else if (tick_ms && ms_cnt != '1) begin
			ms_cnt <= ms_cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flash_cnt <= '0;
			flash_phase <= 1'b1;
		end else if (tick_ms) begin
			if (flash_cnt >= `HOAIO_FLASH_MS - 1'b1) begin
				flash_cnt <= '0;
				flash_phase <= ~flash_phase;
			end else begin
				flash_cnt <= flash_cnt + 1'b1;
			end
		end
	end

	// The stored code only changes on a timed-out edit with a legal selection.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			node_code <= NODE_RESET;
		end else if (ui_state == hoaio_pkg::HOAIO_UI_ADDR_EDIT && !press
			&& ms_cnt >= `HOAIO_EDIT_MS && code_ok(addr_select)) begin
			node_code <= addr_select;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			node_code_valid <= 1'b0;
		end else begin
			node_code_valid <= code_ok(node_code);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			term_enable <= 1'b0;
		end else if (ui_state == hoaio_pkg::HOAIO_UI_TERM_SHOW && press) begin
			term_enable <= ~term_enable;
		end
	end

	assign term_led = term_enable;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			disp_code <= NODE_RESET;
			disp_mode <= hoaio_pkg::HOAIO_DISP_NODE;
			disp_lit <= 1'b1;
		end else begin
			case (ui_state)
				hoaio_pkg::HOAIO_UI_HOLD: begin
					disp_code <= node_code;
					disp_mode <= hoaio_pkg::HOAIO_DISP_ADDR;
					disp_lit <= (ms_cnt < `HOAIO_ADDR_HOLD_MS) | flash_phase;
				end
				hoaio_pkg::HOAIO_UI_ADDR_EDIT: begin
					disp_code <= addr_select;
					disp_mode <= hoaio_pkg::HOAIO_DISP_ADDR;
					disp_lit <= flash_phase;
				end
				hoaio_pkg::HOAIO_UI_TERM_ARM: begin
					disp_code <= node_code;
					disp_mode <= hoaio_pkg::HOAIO_DISP_TERM_EN;
					disp_lit <= flash_phase;
				end
				hoaio_pkg::HOAIO_UI_TERM_SHOW: begin
					disp_code <= {7'h00, term_enable};
					disp_mode <= hoaio_pkg::HOAIO_DISP_TERM_VAL;
					disp_lit <= 1'b1;
				end
				default: begin
					disp_code <= node_code;
					disp_mode <= hoaio_pkg::HOAIO_DISP_NODE;
					disp_lit <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_shed_on <= 1'b0;
			force_on_on <= 1'b0;
		end else begin
			load_shed_on <= load_shed_contact;
			force_on_on <= force_on_contact;
		end
	end

	// Per-circuit aggregation over every sensor mapped to that circuit.
	always_comb begin
		lo_val = '0;
		hi_val = '0;
		seen = 1'b0;
		above = 1'b0;
		flt = 1'b0;
		for (int c = 0; c < NCKT; c++) begin
			seen = 1'b0;
			above = 1'b0;
			flt = 1'b0;
			lo_val = '0;
			hi_val = '0;
			for (int s = 0; s < NSENS; s++) begin
				if (sensor_map[s] == 3'(c + 1)) begin
					if (!seen || sensor_temp[s] < lo_val) begin
						lo_val = sensor_temp[s];
					end
					if (!seen || sensor_temp[s] > hi_val) begin
						hi_val = sensor_temp[s];
					end
					seen = 1'b1;
					above = above | (sensor_temp[s] > high_set[c]);
					flt = flt | sensor_fault[s];
				end
			end
			next_ctrl_temp[c] = above ? hi_val : lo_val;
			next_sensor_fault[c] = flt | ~seen;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int c = 0; c < NCKT; c++) begin
				ctrl_temp[c] <= '0;
				heater_current[c] <= '0;
				leak_current[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NCKT; c++) begin
				ctrl_temp[c] <= next_ctrl_temp[c];
				heater_current[c] <= heater_current_raw[c];
				leak_current[c] <= leak_current_raw[c];
			end
		end
	end

	for (genvar g = 0; g < NCKT; g++) begin : g_ckt
		hoaio_circuit #(
			.TW(TW),
			.MW(MW)
		) u_ckt (
			.sys_clk(sys_clk),
			.reset_n(reset_n),
			.ckt_enable(ckt_enable[g]),
			.heat_demand(heat_demand[g]),
			.load_shed_opt(load_shed_opt[g]),
			.force_on_opt(force_on_opt[g]),
			.load_shed_in(load_shed_on),
			.force_on_in(force_on_on),
			.ctrl_temp(ctrl_temp[g]),
			.high_set(high_set[g]),
			.low_set(low_set[g]),
			.sensor_fault(next_sensor_fault[g]),
			.leak_current(leak_current[g]),
			.leak_limit(leak_limit[g]),
			.over_current(over_current[g]),
			.relay_on(relay_on[g]),
			.alarm_high(alarm_high[g]),
			.alarm_low(alarm_low[g]),
			.alarm_trip(alarm_trip[g])
		);
	end

	// Sub-address read port; codes outside 1 to 6 read as invalid and zero.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_valid <= 1'b0;
			sel_relay <= 1'b0;
			sel_heater_current <= '0;
			sel_leak_current <= '0;
		end else if (sub_addr >= `HOAIO_SUB_MIN && sub_addr <= `HOAIO_SUB_MAX
			&& int'(sub_addr) <= NCKT) begin
			sel_valid <= 1'b1;
			sel_relay <= relay_on[sub_addr - `HOAIO_SUB_MIN];
			sel_heater_current <= heater_current[sub_addr - `HOAIO_SUB_MIN];
			sel_leak_current <= leak_current[sub_addr - `HOAIO_SUB_MIN];
		end else begin
			sel_valid <= 1'b0;
			sel_relay <= 1'b0;
			sel_heater_current <= '0;
			sel_leak_current <= '0;
		end
	end

	// Outputs are energised when healthy so a broken wire also reads as alarm.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_common_ok <= 1'b1;
			out_trip_ok <= 1'b1;
			out_high_ok <= 1'b1;
			out_low_ok <= 1'b1;
			out_system_ok <= 1'b1;
		end else begin
			out_common_ok <= ~(|alarm_trip | |alarm_high | |alarm_low
				| system_fault_in);
			out_trip_ok <= ~(|alarm_trip);
			out_high_ok <= ~(|alarm_high);
			out_low_ok <= ~(|alarm_low);
			out_system_ok <= ~system_fault_in;
		end
	end

endmodule : hoaio_top

// *** bench/hoaio_top_asserts.sv ***
// Port-level assertions for the heater override and alarm node.
`timescale 1ns/10ps

module hoaio_checker #(
	parameter int NCKT = 6
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic system_fault_in,
	input wire logic [NCKT-1:0] load_shed_opt,
	input wire logic [NCKT-1:0] force_on_opt,
	input wire logic [2:0] sub_addr,
	input wire logic [7:0] node_code,
	input wire logic term_enable,
	input wire logic term_led,
	input wire hoaio_pkg::hoaio_disp_t disp_mode,
	input wire logic load_shed_on,
	input wire logic force_on_on,
	input wire logic [NCKT-1:0] relay_on,
	input wire logic [NCKT-1:0] alarm_high,
	input wire logic [NCKT-1:0] alarm_low,
	input wire logic [NCKT-1:0] alarm_trip,
	input wire logic sel_valid,
	input wire logic sel_relay,
	input wire logic out_common_ok,
	input wire logic out_trip_ok,
	input wire logic out_high_ok,
	input wire logic out_low_ok,
	input wire logic out_system_ok
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_shed_start;
		$rose(load_shed_on) && load_shed_opt[0] && !alarm_low[0];
	endsequence
	sequence s_force_start;
		$rose(force_on_on) && force_on_opt[1] && !alarm_high[1]
			&& !(load_shed_on && load_shed_opt[1]);
	endsequence

	a_led_follows_term: assert property (term_led == term_enable)
		else $error("terminator led differs from setting");
	a_node_code_legal: assert property (node_code[7:4] <= 4'h9
		&& node_code[3:0] <= 4'h9 && node_code != 8'h00)
		else $error("node code outside 01 to 99");
	a_shed_drives_off: assert property (s_shed_start |=> !relay_on[0])
		else $error("shed circuit relay still on");
	a_force_drives_on: assert property (s_force_start |=> relay_on[1])
		else $error("forced circuit relay still off");
	a_trip_output_drop: assert property (alarm_trip != '0 |=> !out_trip_ok)
		else $error("trip output stays on during trip");
	a_trip_output_clear: assert property (alarm_trip == '0 |=> out_trip_ok)
		else $error("trip output off without trip");
	a_high_output_drop: assert property (alarm_high != '0 |=> !out_high_ok)
		else $error("high output stays on during alarm");
	a_low_common_drop: assert property (alarm_low != '0
		|=> !out_low_ok && !out_common_ok)
		else $error("low or common output stays on");
	a_system_output_drop: assert property (system_fault_in |-> ##[1:3] !out_system_ok)
		else $error("system output stays on during fault");
	a_term_value_shown: assert property ($past(reset_n) && $changed(term_enable)
		|-> ##[0:2] disp_mode == hoaio_pkg::HOAIO_DISP_TERM_VAL)
		else $error("terminator change not shown");
	a_sel_invalid_addr: assert property (sub_addr == 3'h0 || sub_addr == 3'h7
		|=> !sel_valid && !sel_relay)
		else $error("invalid sub address selected");
	a_sel_valid_addr: assert property (sub_addr >= 3'h1 && sub_addr <= 3'h6
		|=> sel_valid)
		else $error("valid sub address not selected");
endmodule : hoaio_checker

bind hoaio_top hoaio_checker #(.NCKT(NCKT)) u_chk (.*);

// *** bench/hoaio_field.sv ***
// Field side model: sensor readings and their mapping onto heater circuits.
`timescale 1ns/10ps

module hoaio_field (
	input wire logic signed [15:0] t_lo,
	input wire logic signed [15:0] t_hi,
	input wire logic [4:0] hot_idx,
	output logic signed [15:0] sensor_temp [20],
	output logic [2:0] sensor_map [20]
);
	// Sensor i reads t_lo plus i, or t_hi when i equals hot_idx, so the lowest reading of each circuit is known.
	always_comb begin
		for (int i = 0; i < 20; i++) begin
			sensor_temp[i] = (5'(i) == hot_idx) ? t_hi : t_lo + 16'(i);
			sensor_map[i] = 3'(i % 6 + 1);
		end
	end
endmodule : hoaio_field

// *** bench/testbench.sv ***
// Self-checking bench for the heater override and alarm node.
`timescale 1ns/10ps

module testbench;
	localparam int TK = 2;
	logic sys_clk, node_code_valid, term_enable, term_led, disp_lit, load_shed_on, force_on_on;
	logic sel_valid, sel_relay, out_common_ok, out_trip_ok, out_high_ok, out_low_ok, out_system_ok;
	logic reset_n = 1'b0, button = 1'b0, load_shed_contact = 1'b0, force_on_contact = 1'b0;
	logic system_fault_in = 1'b0;
	logic [7:0] addr_select = 8'h01, node_code, disp_code, exp_node = 8'h01;
	// Only one node sits on the link here, so each code it is given is unique in its panel.
	logic [7:0] codes [3] = '{8'h42, 8'h00, 8'h99};
	logic [7:0] want [3] = '{8'h42, 8'h42, 8'h99};
	logic [5:0] ckt_enable = 6'h3f, heat_demand = 6'h3d, load_shed_opt = 6'h01, force_on_opt = 6'h03;
	logic [5:0] over_current = 6'h00, relay_on, alarm_high, alarm_low, alarm_trip;
	logic signed [15:0] high_set [6] = '{default: 16'sd100}, low_set [6] = '{default: 16'sd10};
	logic signed [15:0] t_lo = 16'sd50, t_hi = 16'sd200, ctrl_temp [6], sensor_temp [20];
	logic [11:0] leak_limit [6] = '{default: 12'h100}, leak_current_raw [6] = '{default: 12'h005};
	logic [11:0] heater_current_raw [6] = '{12'h011, 12'h022, 12'h033, 12'h044, 12'h055, 12'h066};
	logic [11:0] heater_current [6], leak_current [6], sel_heater_current, sel_leak_current;
	logic [19:0] sensor_fault = 20'h00000;
	logic [2:0] sensor_map [20], sub_addr = 3'h1;
	logic [4:0] hot_idx = 5'd31;
	hoaio_pkg::hoaio_disp_t disp_mode;
	int mismatches = 0, n_compared = 0;

	hoaio_top #(.TICK_CYCLES(TK)) u_dut (.*);
	hoaio_field u_field (.t_lo(t_lo), .t_hi(t_hi), .hot_idx(hot_idx), .sensor_temp(sensor_temp),
		.sensor_map(sensor_map));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Waits n edges and returns at the following falling edge, where outputs are settled.
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	task automatic press(input int cyc);
		@(posedge sys_clk);
		button <= 1'b1;
		repeat (cyc) @(posedge sys_clk);
		button <= 1'b0;
	endtask : press

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (100000) @(posedge sys_clk);
		mismatches++;
		final_report;
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		settle(1);
		check(alarm_low, 6'h00);
		settle(5);
		check(node_code, 8'h01);
		check(term_led, 1'b0);
		check(out_common_ok, 1'b1);
		check(out_system_ok, 1'b1);
		check(relay_on, 6'h3d);
		$display("test reset done");
		foreach (codes[i]) begin
			@(posedge sys_clk);
			addr_select <= codes[i];
			press(2100 * TK);
			settle(4800 * TK);
			check(disp_mode, hoaio_pkg::HOAIO_DISP_ADDR);
			check(node_code, exp_node);
			settle(400 * TK);
			exp_node = want[i];
			check(node_code, exp_node);
			check(node_code_valid, 1'b1);
		end
		@(posedge sys_clk);
		addr_select <= 8'h17;
		press(2100 * TK);
		settle(200 * TK);
		press(5);
		settle(5200 * TK);
		check(node_code, exp_node);
		press(100 * TK);
		settle(10);
		check(disp_mode, hoaio_pkg::HOAIO_DISP_NODE);
		$display("test address done");
		@(posedge sys_clk);
		button <= 1'b1;
		settle(4100 * TK);
		check(disp_mode, hoaio_pkg::HOAIO_DISP_TERM_EN);
		check(term_enable, 1'b0);
		@(posedge sys_clk);
		button <= 1'b0;
		settle(50 * TK);
		press(5);
		settle(4800 * TK);
		check(term_enable, 1'b1);
		check(term_led, 1'b1);
		check(disp_mode, hoaio_pkg::HOAIO_DISP_TERM_VAL);
		check(disp_lit, 1'b1);
		settle(400 * TK);
		check(disp_mode, hoaio_pkg::HOAIO_DISP_NODE);
		check(disp_code, exp_node);
		$display("test terminator done");
		@(posedge sys_clk);
		load_shed_contact <= 1'b1;
		settle(8);
		check(load_shed_on, 1'b1);
		check(relay_on, 6'h3c);
		@(posedge sys_clk);
		force_on_contact <= 1'b1;
		settle(8);
		check(force_on_on, 1'b1);
		check(relay_on, 6'h3e);
		@(posedge sys_clk);
		t_lo <= 16'sd0;
		settle(8);
		check(alarm_low, 6'h3f);
		check(relay_on, 6'h3f);
		check(out_low_ok, 1'b0);
		check(out_common_ok, 1'b0);
		@(posedge sys_clk);
		t_lo <= 16'sd50;
		load_shed_contact <= 1'b0;
		hot_idx <= 5'd1;
		heat_demand <= 6'h3f;
		settle(8);
		check(ctrl_temp[0], 16'sd50);
		check(ctrl_temp[1], 16'sd200);
		check(alarm_high, 6'h02);
		check(out_high_ok, 1'b0);
		check(relay_on, 6'h3d);
		$display("test override done");
		@(posedge sys_clk);
		force_on_contact <= 1'b0;
		hot_idx <= 5'd31;
		ckt_enable <= 6'h1f;
		over_current <= 6'h08;
		leak_current_raw[4] <= 12'h101;
		heater_current_raw[2] <= 12'h333;
		sub_addr <= 3'h3;
		system_fault_in <= 1'b1;
		settle(8);
		check(relay_on, 6'h1f);
		check(alarm_trip, 6'h18);
		check(out_trip_ok, 1'b0);
		check(out_system_ok, 1'b0);
		check(leak_current[4], 12'h101);
		check(sel_heater_current, 12'h333);
		check(heater_current[2], 12'h333);
		check(sel_leak_current, 12'h005);
		check(sel_relay, 1'b1);
		@(posedge sys_clk);
		sub_addr <= 3'h7;
		sensor_fault <= 20'h80000;
		settle(8);
		check(sel_valid, 1'b0);
		check(alarm_low, 6'h02);
		$display("test alarms done");
		final_report;
	end
endmodule : testbench
